/* psc_pkg.sv */
// Package: register map, field positions, reset values and timing
// constants for the power sequencing and control register bank.
// Assumes a 50 MHz system clock shared by every user of the package.
package psc_pkg;

   // ==========================================================
   // Register addresses, first page
   localparam logic [7:0] ADDR_PAGE_SELECT   = 8'h01;
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h02;
   localparam logic [7:0] ADDR_KEEP_ON       = 8'h03;
   localparam logic [7:0] ADDR_TEST_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_INT_STATUS    = 8'h05;
   localparam logic [7:0] ADDR_OPTIONS       = 8'h06;
   localparam logic [7:0] ADDR_MTX_ENABLE    = 8'h07;
   localparam logic [7:0] ADDR_MTX_SOURCE    = 8'h08;
   localparam logic [7:0] ADDR_MEM_CLEAR     = 8'h09;
   localparam logic [7:0] ADDR_SCROLL_EN     = 8'h0a;
   localparam logic [7:0] ADDR_SCROLL_MODE   = 8'h0b;
   localparam logic [7:0] ADDR_SOFT_RESET    = 8'h0d;
   localparam logic [7:0] ADDR_COL_HIGH      = 8'h10;
   localparam logic [7:0] ADDR_COL_MID       = 8'h11;
   localparam logic [7:0] ADDR_COL_LOW       = 8'h12;
   localparam logic [7:0] ADDR_MAX_CURRENT_SELECT          = 8'h13;
   localparam logic [7:0] ADDR_TEST_FIRST    = 8'h20;
   localparam logic [7:0] ADDR_TEST_LAST     = 8'h41;

   // ==========================================================
   // Writable field masks
   localparam logic [7:0] MASK_BIT0       = 8'h01;
   localparam logic [7:0] MASK_LOW2       = 8'h03;
   localparam logic [7:0] MASK_OPTIONS    = 8'hc3;
   localparam logic [7:0] MASK_SCROLL     = 8'h7f;
   localparam logic [7:0] MASK_FULL       = 8'hff;
   localparam int         PAGE_BIT        = 0;
   localparam int         KEEP_ON_BIT     = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_ZERO        = 8'h00;
   localparam logic [7:0] RST_KEEP_ON     = 8'h01;

   // ==========================================================
   // Timing
   localparam int CLK_HZ                  = 50_000_000;
   localparam int WAKE_DELAY_MS           = 5;
   // More than 5 ms: one cycle beyond the exact count
   localparam int WAKE_DELAY_CYC          = CLK_HZ / 1000 * WAKE_DELAY_MS + 1;
   localparam int WAKE_CNT_W              = 19;

   typedef enum logic [1:0] {
      PSC_OFF  = 2'b00,
      PSC_WAKE = 2'b01,
      PSC_ON   = 2'b10
   } psc_state_t;

endpackage

/* psc_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous level input and the single system clock.
module psc_sync
   import psc_pkg::*;
(
   input  wire logic clk,       // System clock
   input  wire logic rst,       // Synchronous reset, active high
   input  wire logic rst_val,   // Output value held during reset
   input  wire logic async_in,  // Level from outside the domain
   output logic      sync_out   // Filtered level
);
   import psc_pkg::*;

   logic s1_ff, s2_ff, s3_ff, out_ff;
   logic nxt_out;

   // ==========================================================
   // Filter: a change counts once stages two and three agree
   always_comb begin
      nxt_out = out_ff;
      if (s2_ff == s3_ff) begin
         nxt_out = s3_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         // Stages start at the idle level, so no false edge after reset
         s1_ff  <= rst_val;
         s2_ff  <= rst_val;
         s3_ff  <= rst_val;
         out_ff <= rst_val;
      end else begin
         s1_ff  <= async_in;
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign sync_out = rst ? rst_val : out_ff;
endmodule

/* psc_regbank.sv */
// Register file: eight-bit registers of the first page with a
// synchronous-read data register and a default-restore strobe.
// Assumes the caller qualifies writes and reads with access gating.
module psc_regbank
   import psc_pkg::*;
(
   input  wire logic       clk,       // System clock
   input  wire logic       rst,       // Synchronous reset, active high
   input  wire logic       restore,   // Return all settings to defaults
   input  wire logic       wr_en,     // Write strobe
   input  wire logic [7:0] addr,      // Register address
   input  wire logic [7:0] wdata,     // Write data
   input  wire logic [7:0] stat_int,  // Interrupt status from block logic
   output logic [7:0]      rdata,     // Registered read data
   output logic            page_sel,  // Page selection bit
   output logic            keep_on,   // Regulator keep-on bit
   output logic            osc_en     // Oscillator enable
);
   import psc_pkg::*;

   localparam int NREG = 16;
   localparam logic [7:0] WMASK [NREG] = '{
      MASK_BIT0, MASK_BIT0, MASK_BIT0, 8'h00, 8'h00, MASK_OPTIONS, MASK_BIT0,
      MASK_LOW2, MASK_LOW2, MASK_BIT0, MASK_SCROLL, MASK_BIT0, MASK_FULL,
      MASK_FULL, MASK_BIT0, MASK_LOW2};
   localparam logic [7:0] RADDR [NREG] = '{
      ADDR_PAGE_SELECT, ADDR_POWER_CONTROL, ADDR_KEEP_ON, ADDR_TEST_STATUS,
      ADDR_INT_STATUS, ADDR_OPTIONS, ADDR_MTX_ENABLE, ADDR_MTX_SOURCE,
      ADDR_MEM_CLEAR, ADDR_SCROLL_EN, ADDR_SCROLL_MODE, ADDR_SOFT_RESET,
      ADDR_COL_HIGH, ADDR_COL_MID, ADDR_COL_LOW, ADDR_MAX_CURRENT_SELECT};

   logic [7:0] reg_ff [NREG];
   logic [7:0] nxt_reg [NREG];
   logic [7:0] rdata_ff, nxt_rdata;

   // ==========================================================
   // Per-register next value; keep-on defaults to one
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         localparam logic [7:0] DEF = (gi == 2) ? RST_KEEP_ON : RST_ZERO;
         always_comb begin
            nxt_reg[gi] = reg_ff[gi];
            if (restore) begin
               nxt_reg[gi] = DEF;
            end else if (wr_en && addr == RADDR[gi]) begin
               nxt_reg[gi] = wdata & WMASK[gi];
            end
         end
         always_ff @(posedge clk) begin
            if (rst) begin
               reg_ff[gi] <= DEF;
            end else begin
               reg_ff[gi] <= nxt_reg[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read mux; unmapped and test addresses read zero
   always_comb begin
      nxt_rdata = RST_ZERO;
      for (int i = 0; i < NREG; i++) begin
         if (addr == RADDR[i]) begin
            nxt_rdata = reg_ff[i];
         end
      end
      if (addr == ADDR_INT_STATUS) begin
         nxt_rdata = stat_int;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= RST_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata    = rdata_ff;
   assign page_sel = reg_ff[0][PAGE_BIT];
   assign osc_en   = reg_ff[1][0];
   assign keep_on  = reg_ff[2][KEEP_ON_BIT];
endmodule

/* psc_top.sv */
// Top of the power sequencing control block: pin synchronisers,
// regulator on/off state, wake delay and gated register access.
// Assumes a decoded serial front end that offers byte write and read
// strobes; the analog regulator follows reg_on_o.
// Summary of operation
// - Drop all serial traffic while enable pin low and keep-on bit zero.
// - Regulator is on whenever the enable pin is high.
// - No serial access accepted while the reset pin is low.
// - Serial access recognised only after more than 5 ms of enable high.
// - Reset restores every register default; keep-on default is one.
// - Reset during enable high sets keep-on, holding the regulator on.
// - Regulator switching off restores every register default.
// - Bit 0 of 01h picks page: zero first, one second.
// - Reset pin is active low.
// - Serial stage and logic unpowered while the regulator is off.
module psc_top
   import psc_pkg::*;
#(
   parameter int WAKE_CYC = WAKE_DELAY_CYC   // Wake delay, shortenable
)
(
   input  wire logic       clk,              // System clock, 50 MHz
   input  wire logic       rst,              // Synchronous reset, active high
   input  wire logic       reg_enable_pin,   // Regulator enable pin
   input  wire logic       reset_input_n,    // Device reset pin, active low
   input  wire logic       ser_wr,           // Serial write strobe
   input  wire logic       ser_rd,           // Serial read strobe
   input  wire logic [7:0] ser_addr,         // Serial register address
   input  wire logic [7:0] ser_wdata,        // Serial write data
   input  wire logic [7:0] stat_int,         // Interrupt status from matrix logic
   output logic [7:0]      ser_rdata,        // Read data
   output logic            ser_rvalid,       // Read data valid pulse
   output logic            reg_on_o,         // Internal regulator on
   output logic            access_ok_o,      // Serial interface accepting
   output logic            page_sel_o,       // Register page selection
   output logic            osc_en_o          // Oscillator enable
);
   import psc_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic en_s, rstn_s;

   psc_sync u_sync_en (
      .clk      (clk),
      .rst      (rst),
      .rst_val  (1'b0),
      .async_in (reg_enable_pin),
      .sync_out (en_s)
   );

   // Held high in system reset so the pin reset does not fire spuriously
   psc_sync u_sync_rst (
      .clk      (clk),
      .rst      (rst),
      .rst_val  (1'b1),
      .async_in (reset_input_n),
      .sync_out (rstn_s)
   );

   // ==========================================================
   // Power state
   psc_state_t             state_ff, nxt_state;
   logic [WAKE_CNT_W-1:0]  wake_ff, nxt_wake;
   logic                   keep_on;
   logic                   pin_reset;
   logic                   reg_on;
   logic                   restore;
   logic                   access_ok;

   assign pin_reset = ~rstn_s;
   assign reg_on    = en_s | keep_on;

   always_comb begin
      nxt_state = state_ff;
      nxt_wake  = wake_ff;
      case (state_ff)
         PSC_OFF: begin
            // Only the pin can wake the regulator from off
            if (en_s) begin
               nxt_state = PSC_WAKE;
               nxt_wake  = '0;
            end
         end
         PSC_WAKE: begin
            if (!reg_on) begin
               nxt_state = PSC_OFF;
            end else if (wake_ff == WAKE_CNT_W'(WAKE_CYC - 1)) begin
               nxt_state = PSC_ON;
            end else begin
               nxt_wake = wake_ff + 1'b1;
            end
         end
         PSC_ON: begin
            if (!reg_on) begin
               nxt_state = PSC_OFF;
            end
         end
         default: begin
            nxt_state = PSC_OFF;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= PSC_OFF;
         wake_ff  <= '0;
      end else begin
         state_ff <= nxt_state;
         wake_ff  <= nxt_wake;
      end
   end

   // Defaults on pin reset, and when the regulator drops out.
   // Keep-on returns to one on reset; with enable high this latches on.
   assign restore = pin_reset | (state_ff != PSC_OFF && !reg_on);

   // Logic unpowered in off; pin reset blocks; wake delay must elapse
   assign access_ok = (state_ff == PSC_ON) && reg_on && !pin_reset;

   // ==========================================================
   // Register file
   logic [7:0] rdata;
   logic       page_sel;
   logic       osc_en;
   logic       page_hit;
   logic       wr_take;
   logic       rd_take;

   // Second page selected: only 01h stays here, the rest lives outside
   assign page_hit = !page_sel || (ser_addr == ADDR_PAGE_SELECT);
   assign wr_take  = ser_wr & access_ok & page_hit;
   assign rd_take  = ser_rd & access_ok;

   psc_regbank u_regs (
      .clk      (clk),
      .rst      (rst),
      .restore  (restore),
      .wr_en    (wr_take),
      .addr     (ser_addr),
      .wdata    (ser_wdata),
      .stat_int (stat_int),
      .rdata    (rdata),
      .page_sel (page_sel),
      .keep_on  (keep_on),
      .osc_en   (osc_en)
   );

   // ==========================================================
   // Output registers
   logic       rvalid_ff, nxt_rvalid;
   logic       pend_ff, nxt_pend;
   logic       hit_ff, nxt_hit;
   logic       on_ff, nxt_on;
   logic       ok_ff, nxt_ok;
   logic       page_ff, nxt_page;
   logic       osc_ff, nxt_osc;
   logic [7:0] rdata_ff, nxt_rdata;

   // Read pipe: strobe, data register, valid pulse; status registered
   always_comb begin
      nxt_pend   = rd_take;
      nxt_hit    = page_hit;
      nxt_rvalid = pend_ff;
      nxt_rdata  = rdata_ff;
      if (pend_ff) begin
         // Second page reads other than 01h answer zero from this block
         nxt_rdata = hit_ff ? rdata : RST_ZERO;
      end
      nxt_on     = (state_ff != PSC_OFF) & reg_on;
      nxt_ok     = access_ok;
      nxt_page   = page_sel;
      nxt_osc    = osc_en;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pend_ff   <= 1'b0;
         hit_ff    <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff  <= RST_ZERO;
         on_ff     <= 1'b0;
         ok_ff     <= 1'b0;
         page_ff   <= 1'b0;
         osc_ff    <= 1'b0;
      end else begin
         pend_ff   <= nxt_pend;
         hit_ff    <= nxt_hit;
         rvalid_ff <= nxt_rvalid;
         rdata_ff  <= nxt_rdata;
         on_ff     <= nxt_on;
         ok_ff     <= nxt_ok;
         page_ff   <= nxt_page;
         osc_ff    <= nxt_osc;
      end
   end

   assign ser_rdata   = rdata_ff;
   assign ser_rvalid  = rvalid_ff;
   assign reg_on_o    = on_ff;
   assign access_ok_o = ok_ff;
   assign page_sel_o  = page_ff;
   assign osc_en_o    = osc_ff;
endmodule

/* psc_top_properties.sv */
// Checker for psc_top, bound to every instance of it.
// Assumes the wake delay parameter matches the instance.
module psc_top_properties
   import psc_pkg::*;
#(
   parameter int WAKE_CYC = 20                 // Wake delay in cycles
)
(
   input wire logic       clk,                 // Clock
   input wire logic       rst,                 // Reset
   input wire logic       reg_enable_pin,      // Enable pin
   input wire logic       reset_input_n,       // Reset pin
   input wire logic       ser_wr,              // Write strobe
   input wire logic       ser_rd,              // Read strobe
   input wire logic [7:0] ser_addr,            // Address
   input wire logic       ser_rvalid,          // Read valid
   input wire logic       reg_on_o,            // Regulator on
   input wire logic       access_ok_o,         // Access open
   input wire logic       page_sel_o,          // Page bit
   input wire logic       osc_en_o             // Oscillator bit
);
   import psc_pkg::*;

   // ==========================================================
   // Cycles the regulator has been on
   int on_cnt_ff;
   int nxt_on_cnt;
   always_comb nxt_on_cnt = reg_on_o ? on_cnt_ff + 1 : 0;
   always_ff @(posedge clk) on_cnt_ff <= rst ? 0 : nxt_on_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_pin_high; reg_enable_pin [*8]; endsequence
   sequence s_pin_reset; !reset_input_n [*6]; endsequence
   // ==========================================================
   // Properties
   chk_off_no_access: assert property (!reg_on_o |-> !access_ok_o)
      else $error("access open with regulator off");
   chk_pin_powers_on: assert property (s_pin_high |-> reg_on_o)
      else $error("regulator off with enable pin high");
   chk_reset_blocks: assert property (s_pin_reset |-> !access_ok_o)
      else $error("access open during pin reset");
   chk_wake_delay: assert property ($rose(access_ok_o) |-> on_cnt_ff >= WAKE_CYC)
      else $error("access opened before wake delay");
   chk_read_gated: assert property (ser_rvalid |-> $past(ser_rd, 2) && $past(access_ok_o))
      else $error("read answered without accepted strobe");
   chk_page_write: assert property ($rose(page_sel_o) |->
      $past(ser_wr, 2) && $past(ser_addr, 2) == ADDR_PAGE_SELECT)
      else $error("page bit rose without page write");
   chk_osc_write: assert property ($rose(osc_en_o) |->
      $past(ser_wr, 2) && $past(ser_addr, 2) == ADDR_POWER_CONTROL)
      else $error("oscillator bit rose without its write");
   chk_drop_defaults: assert property ($fell(reg_on_o) |-> ##[0:2] !page_sel_o && !osc_en_o)
      else $error("settings kept after regulator drop");
   chk_drop_needs_low: assert property ($fell(reg_on_o) |-> !$past(reg_enable_pin))
      else $error("regulator dropped with enable pin high");
endmodule

bind psc_top psc_top_properties #(.WAKE_CYC(WAKE_CYC)) chk_u (.clk(clk), .rst(rst),
   .reg_enable_pin(reg_enable_pin), .reset_input_n(reset_input_n), .ser_wr(ser_wr),
   .ser_rd(ser_rd), .ser_addr(ser_addr), .ser_rvalid(ser_rvalid), .reg_on_o(reg_on_o),
   .access_ok_o(access_ok_o), .page_sel_o(page_sel_o), .osc_en_o(osc_en_o));

/* psc_host_model.sv */
// Host model: byte write and read strobes toward the block.
// Assumes tasks are entered just after a rising clock edge.
module psc_host_model (
   input  wire logic       clk,         // System clock
   output logic            ser_wr,      // Write strobe
   output logic            ser_rd,      // Read strobe
   output logic [7:0]      ser_addr,    // Register address
   output logic [7:0]      ser_wdata,   // Write data
   input  wire logic [7:0] ser_rdata,   // Read data
   input  wire logic       ser_rvalid   // Read data valid
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      ser_wr = 1'b0;
      ser_rd = 1'b0;
      ser_addr = 8'h00;
      ser_wdata = 8'h00;
   end
   // ==========================================================
   // Transfers; factory test addresses are never issued
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ser_addr = a;
      ser_wdata = d;
      ser_wr = 1'b1;
      @(posedge clk);
      #1;
      ser_wr = 1'b0;
      ser_addr = ~a;
      ser_wdata = ~d;
      // Idle edge keeps the strobe low between back-to-back calls
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      ser_addr = a;
      ser_rd = 1'b1;
      @(posedge clk);
      #1;
      ser_rd = 1'b0;
      ser_addr = ~a;
      ok = 1'b0;
      d = 8'h00;
      repeat (3) begin
         @(posedge clk);
         #1;
         if (ser_rvalid === 1'b1) begin
            ok = 1'b1;
            d = ser_rdata;
         end
      end
   endtask
endmodule

/* test_psc_top.sv */
// Self-checking bench for psc_top with a shortened wake delay.
// Assumes the host model drives the serial strobes.
module test_psc_top;
   import psc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WAKE = 20;
   logic clk, rst, pin_en, pin_rst_n, reg_on, acc_ok, page, osc;
   logic [7:0] stat = 8'h03;
   int err_count, n_checks, cyc;
   logic h_wr, h_rd, h_rvalid;
   logic [7:0] h_addr, h_wdata, h_rdata;
   psc_host_model host_u (.clk(clk), .ser_wr(h_wr), .ser_rd(h_rd), .ser_addr(h_addr),
      .ser_wdata(h_wdata), .ser_rdata(h_rdata), .ser_rvalid(h_rvalid));
   psc_top #(.WAKE_CYC(WAKE)) dut_u (.clk(clk), .rst(rst), .reg_enable_pin(pin_en),
      .reset_input_n(pin_rst_n), .ser_wr(h_wr), .ser_rd(h_rd),
      .ser_addr(h_addr), .ser_wdata(h_wdata), .stat_int(stat),
      .ser_rdata(h_rdata), .ser_rvalid(h_rvalid), .reg_on_o(reg_on),
      .access_ok_o(acc_ok), .page_sel_o(page), .osc_en_o(osc));
   // ==========================================================
   // Shared helpers
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rd_chk(logic [7:0] a, logic vld, logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host_u.rd(a, d, ok);
      check("rvalid", {7'h0, ok}, {7'h0, vld});
      if (vld) check("rdata", d, exp);
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_ok();
      for (int i = 0; i < 200 && acc_ok !== 1'b1; i++) tick(1);
      check("access", {7'h0, acc_ok}, 8'h01);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_power_up();
      pin_en = 1'b1;
      rd_chk(ADDR_KEEP_ON, 1'b0, 8'h00);
      wait_ok();
      check("reg_on", {7'h0, reg_on}, 8'h01);
   endtask
   task automatic t_defaults();
      logic [7:0] a[7] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0b, 8'h13};
      foreach (a[i]) rd_chk(a[i], 1'b1, a[i] == ADDR_KEEP_ON ? RST_KEEP_ON : RST_ZERO);
   endtask
   task automatic t_masks();
      logic [7:0] a[6] = '{8'h06, 8'h0b, 8'h10, 8'h13, 8'h02, 8'h0c};
      logic [7:0] e[6] = '{8'hc3, 8'h7f, 8'hff, 8'h03, 8'h01, 8'h00};
      foreach (a[i]) host_u.wr(a[i], 8'hff);
      foreach (a[i]) rd_chk(a[i], 1'b1, e[i]);
      rd_chk(ADDR_INT_STATUS, 1'b1, stat);
      check("osc", {7'h0, osc}, 8'h01);
      host_u.wr(ADDR_PAGE_SELECT, 8'hff);
      rd_chk(ADDR_PAGE_SELECT, 1'b1, 8'h01);
      check("page", {7'h0, page}, 8'h01);
      rd_chk(ADDR_OPTIONS, 1'b1, 8'h00);
      host_u.wr(ADDR_OPTIONS, 8'h00);
      host_u.wr(ADDR_PAGE_SELECT, 8'h00);
      rd_chk(ADDR_OPTIONS, 1'b1, 8'hc3);
      check("page", {7'h0, page}, 8'h00);
   endtask
   task automatic t_reset_pin();
      pin_rst_n = 1'b0;
      tick(1);
      pin_rst_n = 1'b1;
      tick(8);
      rd_chk(ADDR_OPTIONS, 1'b1, 8'hc3);
      pin_rst_n = 1'b0;
      tick(10);
      check("access", {7'h0, acc_ok}, 8'h00);
      rd_chk(ADDR_OPTIONS, 1'b0, 8'h00);
      pin_rst_n = 1'b1;
      wait_ok();
      rd_chk(ADDR_OPTIONS, 1'b1, 8'h00);
      host_u.wr(ADDR_POWER_CONTROL, 8'h01);
      pin_en = 1'b0;
      tick(10);
      check("reg_on", {7'h0, reg_on}, 8'h01);
   endtask
   task automatic t_off();
      pin_en = 1'b1;
      tick(8);
      host_u.wr(ADDR_KEEP_ON, 8'h00);
      tick(4);
      check("reg_on", {7'h0, reg_on}, 8'h01);
      pin_en = 1'b0;
      tick(10);
      check("reg_on", {7'h0, reg_on}, 8'h00);
      check("page", {7'h0, page}, 8'h00);
      check("osc", {7'h0, osc}, 8'h00);
      pin_rst_n = 1'b0;
      tick(4);
      pin_rst_n = 1'b1;
      rd_chk(ADDR_KEEP_ON, 1'b0, 8'h00);
      pin_en = 1'b1;
      wait_ok();
      rd_chk(ADDR_PAGE_SELECT, 1'b1, 8'h00);
      rd_chk(ADDR_KEEP_ON, 1'b1, 8'h01);
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      rst = 1'b1;
      pin_en = 1'b0;
      pin_rst_n = 1'b1;
      tick(2);
      rst = 1'b0;
      t_power_up();
      t_defaults();
      t_masks();
      t_reset_pin();
      t_off();
      conclude();
   end
endmodule
